// file: slow_clock_regs.sv
`timescale 1ns/100ps
`default_nettype none
module slow_clock_regs
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  slow_ctrl_if.regs        ctl
);
  logic [31:0] aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        do_write;
  logic        ctrl_hit;

  assign awready  = ~aw_have_r & ~bvalid;
  assign wready   = ~w_have_r & ~bvalid;
  assign arready  = ~rvalid;
  assign do_write = aw_have_r & w_have_r & ~bvalid;
  assign ctrl_hit = aw_addr_r == slow_clock_pkg::ctrl_addr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 32'h00000000;
    end
    else if (awvalid && awready)
    begin
      aw_have_r <= 1'b1;
      aw_addr_r <= awaddr;
    end
    else if (do_write)
      aw_have_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_have_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
    else if (do_write)
      w_have_r <= 1'b0;
  end

  // control bits go back to their reset values whenever aresetn is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl.rc_en   <= slow_clock_pkg::rc_en_reset;
      ctl.xtal_en <= slow_clock_pkg::xtal_en_reset;
      ctl.bypass  <= slow_clock_pkg::bypass_reset;
      ctl.select  <= slow_clock_pkg::select_reset;
    end
    else if (do_write && ctrl_hit && w_strb_r[0])
    begin
      ctl.rc_en   <= w_data_r[slow_clock_pkg::rc_en_bit];
      ctl.xtal_en <= w_data_r[slow_clock_pkg::xtal_en_bit];
      ctl.bypass  <= w_data_r[slow_clock_pkg::bypass_bit];
      ctl.select  <= w_data_r[slow_clock_pkg::select_bit];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= slow_clock_pkg::resp_okay;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (ctrl_hit || aw_addr_r == slow_clock_pkg::status_addr) ?
                slow_clock_pkg::resp_okay : slow_clock_pkg::resp_slverr;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= slow_clock_pkg::resp_okay;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= slow_clock_pkg::resp_okay;
      rdata  <= 32'h00000000;
      if (araddr == slow_clock_pkg::ctrl_addr)
      begin
        rdata[slow_clock_pkg::rc_en_bit]   <= ctl.rc_en;
        rdata[slow_clock_pkg::xtal_en_bit] <= ctl.xtal_en;
        rdata[slow_clock_pkg::bypass_bit]  <= ctl.bypass;
        rdata[slow_clock_pkg::select_bit]  <= ctl.select;
      end
      else if (araddr == slow_clock_pkg::status_addr)
      begin
        rdata[0] <= ctl.active_sel;
        rdata[1] <= ctl.busy;
      end
      else
        rresp <= slow_clock_pkg::resp_slverr;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule // slow_clock_regs
`default_nettype wire

// file: slow_clock_pkg.sv
// Behaviour
// - slow clock follows crystal or rc oscillator per slow_source_select.
// - bypass passes the clock on crystal_input_pin straight through, oscillator off.
// - writing 1 to an enable bit turns the matching oscillator on; the crystal only while bypass is 0.
// - enables, select and bypass live in slow_clock_control, kept while powered.
// - backup reset gives rc enable 1, crystal enable 0, select 0.
// - select change resynchronises within 5 slow cycles before old oscillator stops.
package slow_clock_pkg;
  localparam logic [31:0] ctrl_addr       = 32'hFFFFFD50;
  localparam logic [31:0] status_addr     = 32'hFFFFFD54;
  localparam int          rc_en_bit       = 0;
  localparam int          xtal_en_bit     = 1;
  localparam int          bypass_bit      = 2;
  localparam int          select_bit      = 3;
  localparam logic        rc_en_reset     = 1'b1;
  localparam logic        xtal_en_reset   = 1'b0;
  localparam logic        bypass_reset    = 1'b0;
  localparam logic        select_reset    = 1'b0;
  localparam int          resync_edges    = 2;
  localparam int          resync_max      = 5;
  localparam logic [1:0]  resp_okay       = 2'h0;
  localparam logic [1:0]  resp_slverr     = 2'h2;
endpackage

// file: slow_ctrl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface slow_ctrl_if;
  logic rc_en;
  logic xtal_en;
  logic bypass;
  logic select;
  logic active_sel;
  logic busy;
  modport regs (output rc_en, output xtal_en, output bypass, output select, input active_sel, input busy);
  modport sw   (input rc_en, input xtal_en, input bypass, input select, output active_sel, output busy);
endinterface
`default_nettype wire

// file: slow_clock_switch.sv
`timescale 1ns/100ps
`default_nettype none
module slow_clock_switch
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic rc_osc_clk,
  input  wire logic crystal_osc_clk,
  input  wire logic crystal_input_pin,
  output logic      slow_clk,
  slow_ctrl_if.sw   ctl
);
  typedef enum logic [1:0] {st_run = 2'b00, st_sync = 2'b01, st_park = 2'b10} sw_state_e;

  logic [1:0] rc_s_r;
  logic [1:0] osc_s_r;
  logic [1:0] pin_s_r;
  logic       rc_src;
  logic       xtal_src;
  logic       new_src;
  logic       old_src;
  logic       new_prev_r;
  logic [2:0] edges_r;
  sw_state_e  state_r;

  // first stage is read only by the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_s_r  <= 2'h0;
      osc_s_r <= 2'h0;
      pin_s_r <= 2'h0;
    end
    else
    begin
      rc_s_r  <= {rc_s_r[0], rc_osc_clk};
      osc_s_r <= {osc_s_r[0], crystal_osc_clk};
      pin_s_r <= {pin_s_r[0], crystal_input_pin};
    end
  end

  assign rc_src   = ctl.rc_en & rc_s_r[1];
  assign xtal_src = ctl.bypass ? pin_s_r[1] : (ctl.xtal_en & osc_s_r[1]);
  assign new_src  = ctl.select ? xtal_src : rc_src;
  assign old_src  = ctl.active_sel ? xtal_src : rc_src;
  assign ctl.busy = state_r != st_run;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      new_prev_r <= 1'b0;
    else
      new_prev_r <= new_src;
  end

  // new source must tick before the mux moves; a dead source stalls the switch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r        <= st_run;
      edges_r        <= 3'h0;
      ctl.active_sel <= slow_clock_pkg::select_reset;
    end
    else
    begin
      unique case (state_r)
        st_run:
        begin
          edges_r <= 3'h0;
          if (ctl.select != ctl.active_sel)
            state_r <= st_sync;
        end
        st_sync:
        begin
          if (ctl.select == ctl.active_sel)
            state_r <= st_run;
          else if (new_src && !new_prev_r && edges_r < 3'(slow_clock_pkg::resync_edges))
            edges_r <= edges_r + 3'h1;
          else if (edges_r == 3'(slow_clock_pkg::resync_edges) && !old_src && !slow_clk)
            state_r <= st_park;
        end
        // release on a falling edge of the chosen source so its low phase is whole
        st_park:
        begin
          if (new_prev_r && !new_src)
          begin
            ctl.active_sel <= ctl.select;
            state_r        <= st_run;
          end
        end
        default:
          state_r <= st_run;
      endcase
    end
  end

  // parked low from the old fall to the new fall, so no runt pulse either side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      slow_clk <= 1'b0;
    else
      slow_clk <= (state_r == st_park) ? 1'b0 : old_src;
  end
endmodule // slow_clock_switch
`default_nettype wire

// file: slow_clock_source_select.sv
`timescale 1ns/100ps
`default_nettype none
module slow_clock_source_select
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        rc_osc_clk,
  input  wire logic        crystal_osc_clk,
  input  wire logic        crystal_input_pin,
  output logic             rc_osc_enable,
  output logic             crystal_osc_enable,
  output logic             slow_clk
);
  slow_ctrl_if ctl ();

  slow_clock_regs u_regs
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .ctl     (ctl.regs)
  );

  slow_clock_switch u_switch
  (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .rc_osc_clk        (rc_osc_clk),
    .crystal_osc_clk   (crystal_osc_clk),
    .crystal_input_pin (crystal_input_pin),
    .slow_clk          (slow_clk),
    .ctl               (ctl.sw)
  );

  // oscillator enables leave through the register bits; bypass stops the crystal
  assign rc_osc_enable      = ctl.rc_en;
  assign crystal_osc_enable = ctl.xtal_en & ~ctl.bypass;
endmodule // slow_clock_source_select
`default_nettype wire

// file: slow_clock_source_select_props.sv
`timescale 1ns/100ps
`default_nettype none
module slow_clock_source_select_props
(
  input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid,
  input wire logic        rc_osc_enable, crystal_osc_enable, slow_clk,
  input wire logic        rc_osc_clk, crystal_osc_clk, crystal_input_pin,
  input wire logic [31:0] awaddr, wdata,
  input wire logic [3:0]  wstrb
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic aw_w = awvalid && awready && wvalid && wready;
  wire logic wr_c = aw_w && awaddr == slow_clock_pkg::ctrl_addr && wstrb[0];
  property p_rst; $rose(aresetn) |-> rc_osc_enable && !crystal_osc_enable && !slow_clk; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_rc; wr_c |-> ##2 rc_osc_enable == $past(wdata[0], 2); endproperty
  a_rc: assert property (p_rc) else $error("rc enable wrong");
  property p_xt; wr_c |-> ##2 crystal_osc_enable == ($past(wdata[1], 2) && !$past(wdata[2], 2)); endproperty
  a_xt: assert property (p_xt) else $error("crystal enable wrong");
  property p_bv; aw_w |-> ##[1:2] bvalid; endproperty
  a_bv: assert property (p_bv) else $error("no write answer");
  property p_rv; arvalid && arready |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  // sources are far slower than aclk, so a level under three cycles is a runt
  property p_hi; $rose(slow_clk) |=> slow_clk[*2]; endproperty
  a_hi: assert property (p_hi) else $error("runt high");
  property p_lo; $fell(slow_clk) |=> !slow_clk[*2]; endproperty
  a_lo: assert property (p_lo) else $error("runt low");
  property p_idle; (!rc_osc_clk && !crystal_osc_clk && !crystal_input_pin)[*6] |-> !slow_clk; endproperty
  a_idle: assert property (p_idle) else $error("slow clock from nowhere");
  c_wr: cover property (wr_c);
  c_rd: cover property (arvalid && arready);
  c_clk: cover property ($rose(slow_clk));
endmodule // slow_clock_source_select_props
bind slow_clock_source_select slow_clock_source_select_props props_i (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .rc_osc_enable, .crystal_osc_enable, .slow_clk,
  .rc_osc_clk, .crystal_osc_clk, .crystal_input_pin, .awaddr, .wdata, .wstrb);
`default_nettype wire

// file: slow_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module slow_osc_model
(
  input  wire logic rc_on,
  input  wire logic xtal_on,
  input  wire logic ext_on,
  output var logic  rc_clk,
  output var logic  xtal_clk,
  output var logic  ext_clk
);
  // stopped oscillators sit low; periods shrunk to keep switches short
  initial {rc_clk, xtal_clk, ext_clk} = 3'h0;
  always #170 rc_clk = rc_on ? ~rc_clk : 1'h0;
  always #330 xtal_clk = xtal_on ? ~xtal_clk : 1'h0;
  always #250 ext_clk = ext_on ? ~ext_clk : 1'h0;
endmodule // slow_osc_model
`default_nettype wire

// file: tb_slow_clock_source_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_slow_clock_source_select;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_on;
  logic        awready, wready, bvalid, arready, rvalid, rc_clk, xt_clk, ext_clk, rc_en, xt_en, slow_clk;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          errors, cmp_count, cyc, c0;
  localparam logic [31:0] ca = slow_clock_pkg::ctrl_addr;
  localparam logic [31:0] sa = slow_clock_pkg::status_addr;
  slow_clock_source_select dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rc_osc_clk(rc_clk),
    .crystal_osc_clk(xt_clk), .crystal_input_pin(ext_clk), .rc_osc_enable(rc_en), .crystal_osc_enable(xt_en), .slow_clk);
  slow_osc_model osc (.rc_on(rc_en), .xtal_on(xt_en), .ext_on, .rc_clk, .xtal_clk(xt_clk), .ext_clk);
  initial
  begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input logic [31:0] a, v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  // busy must clear within five cycles of the new source (half period h)
  task sel_wait(input logic [31:0] v, input int h, input logic [31:0] act);
    wr(ca, v);
    c0 = cyc;
    repeat (200)
    begin
      rd(sa);
      if (rd_v[1] === 1'h0)
        break;
    end
    chk({31'h0, (cyc - c0) <= 2 * slow_clock_pkg::resync_max * h + 6}, 32'h1, "resync time");
    chk(rd_v, act, "status");
  endtask
  function automatic logic [31:0] en_exp(logic [31:0] v);
    return {30'h0, v[0], v[1] & ~v[2]};
  endfunction
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_on} = 7'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    d = $urandom(39);
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ca);
    chk(rd_v, 32'h1, "ctrl reset");
    chk({30'h0, rc_en, xt_en}, 32'h2, "enables reset");
    rd(sa + 32'h4);
    chk({30'h0, rsp}, 32'h2, "unmapped resp");
    $display("test reset done");
    wr(ca, 32'h3);
    repeat (50) @(posedge aclk);
    sel_wait(32'hB, 17, 32'h1);
    wr(ca, 32'hA);
    chk({30'h0, rc_en, xt_en}, 32'h1, "rc off crystal on");
    $display("test to crystal done");
    wr(ca, 32'hB);
    repeat (50) @(posedge aclk);
    sel_wait(32'h3, 9, 32'h0);
    wr(ca, 32'h1);
    // bypass is set up while the rc clock is the live source
    ext_on <= 1'h1;
    wr(ca, 32'h7);
    chk({31'h0, xt_en}, 32'h0, "bypass crystal off");
    wr(ca, 32'h5);
    sel_wait(32'hD, 13, 32'h1);
    wr(ca, 32'hC);
    chk({30'h0, rc_en, xt_en}, 32'h0, "bypass rc off");
    wr(ca, 32'hD);
    repeat (50) @(posedge aclk);
    sel_wait(32'h5, 9, 32'h0);
    wr(ca, 32'h1);
    ext_on <= 1'h0;
    $display("test to rc done");
    repeat (8)
    begin
      d = ($urandom & 32'hFFFFFFF7) | 32'h00000001;
      wr(ca, d);
      rd(ca);
      chk(rd_v, {28'h0, d[3:0]}, "ctrl readback");
      chk({30'h0, rc_en, xt_en}, en_exp(d), "enables");
    end
    // lane 0 off: control bits must stay as they are
    wstrb <= 4'hE;
    wr(ca, 32'h0);
    rd(ca);
    chk(rd_v, {28'h0, d[3:0]}, "masked write");
    wstrb <= 4'hF;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ca);
    chk(rd_v, 32'h1, "ctrl second reset");
    chk({30'h0, rc_en, xt_en}, 32'h2, "enables second reset");
    $display("test random done");
    give_verdict();
  end
endmodule // tb_slow_clock_source_select
`default_nettype wire
